// File: shared/fault_pkg.sv
/*
   shared constants for the per-channel fault protection block: register
   offsets, field positions, reset values, timer figures and the channel state.
   assumes 8-bit register data and a 4-bit register address.
*/
package fault_pkg;
   localparam int NCH = 2;
   localparam int STRIDE = 4; // per-channel field stride inside shared registers

   // register offsets
   localparam logic [3:0] A_CTRL = 4'h0;
   localparam logic [3:0] A_EN_A = 4'h1;
   localparam logic [3:0] A_EN_B = 4'h2;
   localparam logic [3:0] A_LATCH = 4'h3;
   localparam logic [3:0] A_MFT = 4'h4;
   localparam logic [3:0] A_LIMIT = 4'h5;
   localparam logic [3:0] A_IFT = 4'h6;
   localparam logic [3:0] A_MODE = 4'h7;
   localparam logic [3:0] A_FLAGS_A = 4'h8;
   localparam logic [3:0] A_FLAGS_B = 4'h9;
   localparam logic [3:0] A_STATUS = 4'ha;

   // fields (bit within a channel slice; pin clear and the shared timing, heat and power flag bits are absolute)
   localparam int CTRL_PIN_CLR = 4;
   localparam int EA_FB_HIGH = 0;
   localparam int EA_FB_LOW = 1;
   localparam int EA_RAMP = 2;
   localparam int EB_LIMIT = 0;
   localparam int EB_LOAD_HIGH = 1;
   localparam int EB_SENSE_OPEN = 2;
   localparam int EB_FB_OPEN = 3;
   localparam int LS_FB_HIGH = 0;
   localparam int LS_FB_LOW = 1;
   localparam int LS_LIMIT = 2;
   localparam int LS_LOAD_HIGH = 3;
   localparam int FA_HIGH = 0;
   localparam int FA_LOW = 1;
   localparam int FA_LIMIT = 2;
   localparam int FA_LOAD = 3;
   localparam int FB_UNDER = 0;
   localparam int FB_SENSE = 1;
   localparam int FB_TIMING = 4;
   localparam int FB_HEAT = 5;
   localparam int FB_PWR = 6;
   localparam int MFT_W = 4; // mft select width per channel
   localparam int LIM_W = 2; // cap select / count max / ift select width

   // reset values
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [7:0] RST_EN_A = 8'h77; // over, under and ramp fault enables on
   localparam logic [7:0] RST_FLAGS_B = 8'h40; // power-cycled bit set

   // timer figures, in channel switching clock periods
   localparam logic [13:0] MFT_MIN = 14'h03e8; // 1000
   localparam logic [13:0] MFT_MAX = 14'h3fff; // 16383
   localparam logic [13:0] MFT_STEP = 14'h0401; // 1025
   localparam logic [5:0] IFT_BASE = 6'h04; // 4, doubled per step up to 32
   localparam logic [6:0] LIMIT_WINDOW = 7'h64; // 100

   typedef enum logic [2:0] {
      ST_OFF = 3'b001,
      ST_ARM = 3'b010,
      ST_RUN = 3'b100
   } chan_state_t;
endpackage : fault_pkg

// File: core/sync_bank.sv
/*
   two-flop synchroniser for a bus of independent levels.
   assumes each bit is a slow level; no coherency between bits is promised.
*/
`timescale 1ns/1ps
module sync_bank #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : sync_bank

// File: core/fault_timer.sv
/*
   one-shot fault timer: counts limit ticks after start, then holds done.
   assumes tick is a one-cycle enable on the same clock and limit is non-zero.
*/
`timescale 1ns/1ps
module fault_timer #(
   parameter int W = 14
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic clear,
   input wire logic start,
   input wire logic tick,
   input wire logic [W-1:0] limit,
   output logic busy,
   output logic done
);
   logic [W-1:0] cnt_q;
   wire [W-1:0] cnt_inc = cnt_q + 1'b1;
   wire hit = (cnt_inc == limit);

   always_ff @(posedge clk) begin
      if (rst || clear) begin
         cnt_q <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else if (start) begin
         cnt_q <= '0;
         busy <= 1'b1;
         done <= 1'b0;
      end else if (busy && tick) begin
         cnt_q <= cnt_inc;
         busy <= !hit;
         done <= hit;
      end
   end
endmodule : fault_timer

// File: core/fault_protect.sv
/*
   two-channel fault protection: comparator inputs, enable and latch settings,
   current-limit event counting, main and current-limit fault timers, channel
   run control, compensation pull-down and active-low fault pins.
   assumes comparator, switching clock and pin-open inputs are asynchronous
   levels; the soft-start ramp lives outside and reports through RAMP_BUSY_IN.
*/
// The implementer's own choices: strobed register access and the placing of the registers.
// Operation
// - per-channel 14-bit main timer, 4-bit select
// - main timer spans 1000 to 16383 switch periods
// - only unlatched low-output or load-high start timer
// - enabled feedback-high fault turns channel off
// - latched feedback-high: off until on bit rewritten
// - unlatched feedback-high: restart when fault clears
// - enabled feedback-low fault turns channel off
// - latched feedback-low: off until on bit rewritten
// - unlatched feedback-low: restart after clear and timer (code waits for the timer only)
// - feedback-low ignored during ramp unless ramp faults on
// - switch current cap always ends on-time
// - enabled limit events counted, trip at maximum
// - limit event counter cleared every 100 switch periods
// - latched limit trip: off until on bit rewritten
// - unlatched limit trip: limit timer then restart
// - limit timer lasts 4 to 32 switch periods
// - limit fault suppressed during constant-voltage ramp unless ramp faults on
// - enabled load-high fault above set point
// - load-high latched or timed restart
// - load-low only sets its read flag
// - open pins latch off; timing pin both
// - faults pull compensation low; start needs discharge
// - flag read clears flags whose cause vanished
// - faults except under-current and heat warning drive pins
`timescale 1ns/1ps
module fault_protect (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   input wire logic [1:0] SW_CLK_IN,
   input wire logic [1:0] FB_HIGH_IN,
   input wire logic [1:0] FB_LOW_IN,
   input wire logic [1:0] SW_CAP_IN,
   input wire logic [1:0] LOAD_HIGH_IN,
   input wire logic [1:0] LOAD_LOW_IN,
   input wire logic [1:0] SENSE_OPEN_IN,
   input wire logic [1:0] FB_OPEN_IN,
   input wire logic [1:0] COMP_LOW_IN,
   input wire logic [1:0] RAMP_BUSY_IN,
   input wire logic TIMING_OPEN_IN,
   input wire logic HEAT_WARN_IN,
   input wire logic HEAT_SHUT_IN,
   output logic [1:0] CH_RUN,
   output logic [1:0] COMP_PULL,
   output logic [1:0] ON_TIME_END,
   output logic [1:0] CAP_SEL0,
   output logic [1:0] CAP_SEL1,
   output logic [1:0] REF_CV,
   output logic [1:0] FAULT_N
);
   // registers
   logic [1:0] on_q;
   logic [7:0] en_a_q;
   logic [7:0] en_b_q;
   logic [7:0] latch_q;
   logic [7:0] mft_q;
   logic [7:0] limit_q;
   logic [3:0] ift_q;
   logic [1:0] mode_q;
   logic [7:0] flags_a_q;
   logic [7:0] flags_b_q;
   logic rd_a_q;
   logic rd_b_q;
   logic [1:0] fpin_n_q;

   // per-channel results gathered for the shared registers
   logic [1:0] on_clr;
   logic [1:0] fpin_set;
   logic [1:0] run_st;
   logic [1:0] arm_st;
   logic [7:0] fa_set;
   logic [7:0] fa_cond;
   logic [7:0] fb_set;
   logic [7:0] fb_cond;

   // synchronised pins: ten per channel, then three shared
   logic [22:0] pins_s;
   sync_bank #(.W(23)) u_sync (
      .clk(SYS_CLK),
      .rst(RST),
      .d({HEAT_SHUT_IN, HEAT_WARN_IN, TIMING_OPEN_IN,
          RAMP_BUSY_IN, COMP_LOW_IN, FB_OPEN_IN, SENSE_OPEN_IN,
          LOAD_LOW_IN, LOAD_HIGH_IN, SW_CAP_IN, FB_LOW_IN, FB_HIGH_IN, SW_CLK_IN}),
      .q(pins_s)
   );
   wire [1:0] clk_s = pins_s[1:0];
   wire [1:0] fbh_s = pins_s[3:2];
   wire [1:0] fbl_s = pins_s[5:4];
   wire [1:0] cap_s = pins_s[7:6];
   wire [1:0] ldh_s = pins_s[9:8];
   wire [1:0] ldl_s = pins_s[11:10];
   wire [1:0] sop_s = pins_s[13:12];
   wire [1:0] fop_s = pins_s[15:14];
   wire [1:0] cpl_s = pins_s[17:16];
   wire [1:0] rmp_s = pins_s[19:18];
   wire tmo_s = pins_s[20];
   wire heat_warn_s = pins_s[21];
   wire heat_shut_s = pins_s[22];

   // bus decode
   wire wr_ctrl = WR && (ADDR == fault_pkg::A_CTRL);
   wire pin_clr = wr_ctrl && WDATA[fault_pkg::CTRL_PIN_CLR];
   wire rd_flags_a = RD && (ADDR == fault_pkg::A_FLAGS_A);
   wire rd_flags_b = RD && (ADDR == fault_pkg::A_FLAGS_B);
   logic [7:0] rd_mux;
   always_comb begin
      case (ADDR)
         fault_pkg::A_CTRL: rd_mux = {6'h00, on_q};
         fault_pkg::A_EN_A: rd_mux = en_a_q;
         fault_pkg::A_EN_B: rd_mux = en_b_q;
         fault_pkg::A_LATCH: rd_mux = latch_q;
         fault_pkg::A_MFT: rd_mux = mft_q;
         fault_pkg::A_LIMIT: rd_mux = limit_q;
         fault_pkg::A_IFT: rd_mux = {4'h0, ift_q};
         fault_pkg::A_MODE: rd_mux = {6'h00, mode_q};
         fault_pkg::A_FLAGS_A: rd_mux = flags_a_q;
         fault_pkg::A_FLAGS_B: rd_mux = flags_b_q;
         fault_pkg::A_STATUS: rd_mux = {2'h0, arm_st, 2'h0, run_st};
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         en_a_q <= fault_pkg::RST_EN_A;
         en_b_q <= fault_pkg::RST_REG;
         latch_q <= fault_pkg::RST_REG;
         mft_q <= fault_pkg::RST_REG;
         limit_q <= fault_pkg::RST_REG;
         ift_q <= 4'h0;
         mode_q <= 2'h0;
      end else if (WR) begin
         case (ADDR)
            fault_pkg::A_EN_A: en_a_q <= WDATA;
            fault_pkg::A_EN_B: en_b_q <= WDATA;
            fault_pkg::A_LATCH: latch_q <= WDATA;
            fault_pkg::A_MFT: mft_q <= WDATA;
            fault_pkg::A_LIMIT: limit_q <= WDATA;
            fault_pkg::A_IFT: ift_q <= WDATA[3:0];
            fault_pkg::A_MODE: mode_q <= WDATA[1:0];
            default: ;
         endcase
      end
   end

   // a latched trip in the same cycle as a write of 1 wins unless the channel is in ST_OFF: safety first
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         on_q <= 2'h0;
      end else begin
         on_q <= (wr_ctrl ? WDATA[1:0] : on_q) & ~on_clr;
      end
   end

   // flags: a fresh event outranks the read clear of the same cycle
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         rd_a_q <= 1'b0;
         rd_b_q <= 1'b0;
         flags_a_q <= fault_pkg::RST_REG;
         flags_b_q <= fault_pkg::RST_FLAGS_B;
         RDATA <= 8'h00;
      end else begin
         rd_a_q <= rd_flags_a;
         rd_b_q <= rd_flags_b;
         RDATA <= RD ? rd_mux : 8'h00;
         // clear lands with the cycle that carries the read data
         flags_a_q <= fa_set | (flags_a_q & ~({8{rd_a_q}} & ~fa_cond));
         flags_b_q <= fb_set | (flags_b_q & ~({8{rd_b_q}} & ~fb_cond));
      end
   end

   // fault pins hold until software clears them
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         fpin_n_q <= 2'h3;
      end else begin
         fpin_n_q <= ~(fpin_set | (~fpin_n_q & {2{!pin_clr}}));
      end
   end
   assign FAULT_N = fpin_n_q;

   // shared diagnostic flags; power-cycled only clears on read
   assign fb_set[fault_pkg::FB_TIMING] = tmo_s;
   assign fb_cond[fault_pkg::FB_TIMING] = tmo_s;
   assign fb_set[fault_pkg::FB_HEAT] = heat_warn_s;
   assign fb_cond[fault_pkg::FB_HEAT] = heat_warn_s;
   assign fb_set[fault_pkg::FB_PWR] = 1'b0;
   assign fb_cond[fault_pkg::FB_PWR] = 1'b0;
   assign fb_set[7] = 1'b0;
   assign fb_cond[7] = 1'b0;
   // bits 3:0 are driven per channel from the loop below

   assign CAP_SEL0 = limit_q[1:0];
   assign CAP_SEL1 = limit_q[5:4];
   assign REF_CV = mode_q;

   genvar gi;
   generate
      for (gi = 0; gi < fault_pkg::NCH; gi++) begin : g_ch
         localparam int B = gi * fault_pkg::STRIDE;
         fault_pkg::chan_state_t st_q;
         fault_pkg::chan_state_t st_d;
         logic clk_d_q;
         logic cap_d_q;
         logic ov_d_q;
         logic uv_d_q;
         logic oc_d_q;
         logic hit_d_q;
         logic run_q;
         logic pull_q;
         logic end_q;
         logic [6:0] win_q;
         logic [2:0] lim_cnt_q;

         wire tick = clk_s[gi] && !clk_d_q;
         wire running = (st_q == fault_pkg::ST_RUN);
         wire ramp_mask = rmp_s[gi] && !en_a_q[B + fault_pkg::EA_RAMP];
         wire fop_f = en_b_q[B + fault_pkg::EB_FB_OPEN] && fop_s[gi];
         wire sop_f = en_b_q[B + fault_pkg::EB_SENSE_OPEN] && sop_s[gi];
         wire ov = en_a_q[B + fault_pkg::EA_FB_HIGH] && fbh_s[gi];
         wire uv = en_a_q[B + fault_pkg::EA_FB_LOW] && fbl_s[gi]
                   && !ramp_mask && running;
         wire oc = en_b_q[B + fault_pkg::EB_LOAD_HIGH] && ldh_s[gi];
         wire ls_ov = latch_q[B + fault_pkg::LS_FB_HIGH];
         wire ls_uv = latch_q[B + fault_pkg::LS_FB_LOW];
         wire ls_lim = latch_q[B + fault_pkg::LS_LIMIT];
         wire ls_oc = latch_q[B + fault_pkg::LS_LOAD_HIGH];

         // limit events: rising cap edges while switching
         wire lim_mask = mode_q[gi] && ramp_mask;
         wire cap_evt = cap_s[gi] && !cap_d_q && running && !lim_mask
                        && en_b_q[B + fault_pkg::EB_LIMIT];
         wire [2:0] lim_max = {1'b0, limit_q[B + 2 +: fault_pkg::LIM_W]} + 3'h1;
         wire hit = (lim_cnt_q >= lim_max);
         wire win_end = tick && (win_q == fault_pkg::LIMIT_WINDOW - 7'h01);

         // latched trips end the run and drop the on bit
         wire ov_rise = ov && !ov_d_q;
         wire uv_rise = uv && !uv_d_q;
         wire oc_rise = oc && !oc_d_q;
         wire hit_rise = hit && !hit_d_q;
         wire latched_trip = (ov_rise && ls_ov) || (uv_rise && ls_uv)
                             || (oc_rise && ls_oc) || (hit_rise && ls_lim)
                             || sop_f || fop_f || tmo_s;
         wire mft_trig = (uv_rise && !ls_uv) || (oc_rise && !ls_oc);
         wire ift_trig = hit_rise && !ls_lim;
         wire soft_trip = (ov && !ls_ov) || mft_trig || ift_trig || heat_shut_s;

         // timer lengths from the select fields
         wire [3:0] mft_sel = mft_q[gi * fault_pkg::MFT_W +: fault_pkg::MFT_W];
         wire [13:0] mft_len = (mft_sel == 4'hf) ? fault_pkg::MFT_MAX
                               : fault_pkg::MFT_MIN + 14'(mft_sel) * fault_pkg::MFT_STEP;
         wire [5:0] ift_len = fault_pkg::IFT_BASE << ift_q[gi * 2 +: 2];
         wire mft_busy;
         wire ift_busy;

         fault_timer #(.W(14)) u_mft (
            .clk(SYS_CLK),
            .rst(RST),
            .clear(!on_q[gi]),
            .start(mft_trig),
            .tick(tick),
            .limit(mft_len),
            .busy(mft_busy),
            .done()
         );
         fault_timer #(.W(6)) u_ift (
            .clk(SYS_CLK),
            .rst(RST),
            .clear(!on_q[gi]),
            .start(ift_trig),
            .tick(tick),
            .limit(ift_len),
            .busy(ift_busy),
            .done()
         );

         // start only when every hold has released and comp is discharged
         wire may_start = cpl_s[gi] && !ov && !oc && !hit && !heat_shut_s
                          && !sop_f && !fop_f && !tmo_s
                          && !mft_busy && !ift_busy;

         always_comb begin
            st_d = st_q;
            case (st_q)
               fault_pkg::ST_OFF: begin
                  if (on_q[gi]) st_d = fault_pkg::ST_ARM;
               end
               fault_pkg::ST_ARM: begin
                  if (!on_q[gi] || latched_trip) st_d = fault_pkg::ST_OFF;
                  else if (may_start) st_d = fault_pkg::ST_RUN;
               end
               fault_pkg::ST_RUN: begin
                  if (!on_q[gi] || latched_trip) st_d = fault_pkg::ST_OFF;
                  else if (soft_trip) st_d = fault_pkg::ST_ARM;
               end
               default: st_d = fault_pkg::ST_OFF;
            endcase
         end

         always_ff @(posedge SYS_CLK) begin
            if (RST) begin
               st_q <= fault_pkg::ST_OFF;
               run_q <= 1'b0;
               pull_q <= 1'b1;
               end_q <= 1'b0;
               clk_d_q <= 1'b0;
               cap_d_q <= 1'b0;
               ov_d_q <= 1'b0;
               uv_d_q <= 1'b0;
               oc_d_q <= 1'b0;
               hit_d_q <= 1'b0;
            end else begin
               st_q <= st_d;
               run_q <= (st_d == fault_pkg::ST_RUN);
               pull_q <= (st_d != fault_pkg::ST_RUN);
               end_q <= cap_s[gi];
               clk_d_q <= clk_s[gi];
               cap_d_q <= cap_s[gi];
               ov_d_q <= ov;
               uv_d_q <= uv;
               oc_d_q <= oc;
               hit_d_q <= hit;
            end
         end

         // event counter and its 100-period clearing window
         always_ff @(posedge SYS_CLK) begin
            if (RST || !on_q[gi]) begin
               win_q <= 7'h00;
               lim_cnt_q <= 3'h0;
            end else begin
               if (tick) win_q <= win_end ? 7'h00 : win_q + 7'h01;
               if (win_end) lim_cnt_q <= 3'h0;
               else if (cap_evt && !hit) lim_cnt_q <= lim_cnt_q + 3'h1;
            end
         end

         assign CH_RUN[gi] = run_q;
         assign COMP_PULL[gi] = pull_q;
         assign ON_TIME_END[gi] = end_q;
         assign run_st[gi] = running;
         assign arm_st[gi] = (st_q == fault_pkg::ST_ARM);
         assign on_clr[gi] = latched_trip && (st_q != fault_pkg::ST_OFF);
         // under-current and heat warning stay off the pins
         assign fpin_set[gi] = ov_rise || uv_rise || oc_rise || hit_rise
                               || sop_f || fop_f || tmo_s || heat_shut_s;
         assign fa_set[B + fault_pkg::FA_HIGH] = ov || fop_f;
         assign fa_cond[B + fault_pkg::FA_HIGH] = ov || fop_f;
         assign fa_set[B + fault_pkg::FA_LOW] = uv;
         assign fa_cond[B + fault_pkg::FA_LOW] = uv;
         assign fa_set[B + fault_pkg::FA_LIMIT] = hit;
         assign fa_cond[B + fault_pkg::FA_LIMIT] = hit;
         assign fa_set[B + fault_pkg::FA_LOAD] = oc;
         assign fa_cond[B + fault_pkg::FA_LOAD] = oc;
         assign fb_set[gi * 2 + fault_pkg::FB_UNDER] = ldl_s[gi];
         assign fb_cond[gi * 2 + fault_pkg::FB_UNDER] = ldl_s[gi];
         assign fb_set[gi * 2 + fault_pkg::FB_SENSE] = sop_f;
         assign fb_cond[gi * 2 + fault_pkg::FB_SENSE] = sop_f;
      end
   endgenerate
endmodule : fault_protect

// File: tb/fault_protect_assertions.sv
/* port checker for fault_protect.
   assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
module fault_protect_assertions (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   input wire logic [1:0] SW_CAP_IN,
   input wire logic [1:0] FB_HIGH_IN,
   input wire logic [1:0] COMP_LOW_IN,
   input wire logic TIMING_OPEN_IN,
   input wire logic HEAT_SHUT_IN,
   input wire logic [1:0] CH_RUN,
   input wire logic [1:0] COMP_PULL,
   input wire logic [1:0] ON_TIME_END,
   input wire logic [1:0] FAULT_N
);
   // cycles since reset release; history before that is not trusted
   logic [2:0] age_q;
   always_ff @(posedge SYS_CLK) begin
      if (RST)
         age_q <= 3'h0;
      else if (age_q != 3'h7)
         age_q <= age_q + 3'h1;
   end
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   sequence high_on_run;
      CH_RUN[0] && FB_HIGH_IN[0] ##1 FB_HIGH_IN[0] [*4];
   endsequence
   pull_vs_run_a: assert property (COMP_PULL == ~CH_RUN)
      else $error("pull-down not opposite to run");
   start_discharged_a: assert property ($rose(CH_RUN[0]) |-> $past(COMP_LOW_IN[0], 3))
      else $error("channel started with node charged");
   high_turns_off_a: assert property (high_on_run |-> !CH_RUN[0])
      else $error("over-voltage did not stop channel");
   high_drives_pin_a: assert property (high_on_run |-> !FAULT_N[0])
      else $error("over-voltage did not drive fault pin");
   timing_both_off_a: assert property (
      TIMING_OPEN_IN [*5] ##0 age_q == 3'h7 |-> CH_RUN == 2'h0)
      else $error("open timing pin left a channel on");
   heat_stop_a: assert property (HEAT_SHUT_IN [*5] ##0 age_q == 3'h7 |-> CH_RUN == 2'h0)
      else $error("shutdown left a channel on");
   cap_ends_on_a: assert property (
      age_q == 3'h7 |-> ON_TIME_END == $past(SW_CAP_IN, 3))
      else $error("on-time end does not follow cap");
   read_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
      else $error("read data outside read cycle");
endmodule : fault_protect_assertions

bind fault_protect fault_protect_assertions chk_i (.SYS_CLK(SYS_CLK), .RST(RST), .RD(RD),
   .RDATA(RDATA), .SW_CAP_IN(SW_CAP_IN), .FB_HIGH_IN(FB_HIGH_IN), .COMP_LOW_IN(COMP_LOW_IN),
   .TIMING_OPEN_IN(TIMING_OPEN_IN), .HEAT_SHUT_IN(HEAT_SHUT_IN), .CH_RUN(CH_RUN),
   .COMP_PULL(COMP_PULL), .ON_TIME_END(ON_TIME_END), .FAULT_N(FAULT_N));

// File: tb/power_stage_model.sv
/* model of the power stage: switching clocks and compensation node.
   assumes the same system clock as the block. */
`timescale 1ns/1ps
module power_stage_model (
   input wire logic clk,
   input wire logic [1:0] pull,
   output logic [1:0] sw_clk,
   output logic [1:0] comp_low
);
   logic [1:0] div_q = 2'h0;
   logic [2:0] d0_q = 3'h0;
   logic [2:0] d1_q = 3'h0;
   // two cycles high, two low, channels in antiphase
   assign sw_clk = {~div_q[1], div_q[1]};
   // node reads discharged only after three cycles of pull-down
   assign comp_low = {&d1_q, &d0_q};
   always_ff @(posedge clk) begin
      div_q <= div_q + 2'h1;
      d0_q <= {d0_q[1:0], pull[0]};
      d1_q <= {d1_q[1:0], pull[1]};
   end
endmodule : power_stage_model

// File: tb/fault_protect_tb.sv
/* self-checking bench for fault_protect with the power stage model.
   assumes the checker is bound from its own file. */
`timescale 1ns/1ps
module fault_protect_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic [1:0] fb_high = 2'h0, fb_low = 2'h0, sw_cap = 2'h0, load_low = 2'h0, ramp = 2'h0;
   logic t_open = 1'b0, heat_shut = 1'b0;
   logic [1:0] load_high = 2'h0, s_open = 2'h0;
   logic [7:0] rdata;
   logic [1:0] sw_clk, comp_low, ch_run, pull, ot_end, fault_n;
   int n_fail = 0;
   int tests_run = 0;
   logic [20:0] rows [9];
   always #12.5 clk = ~clk;
   fault_protect uut (.SYS_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
      .RD(rd_s), .RDATA(rdata), .SW_CLK_IN(sw_clk), .FB_HIGH_IN(fb_high),
      .FB_LOW_IN(fb_low), .SW_CAP_IN(sw_cap), .LOAD_HIGH_IN(load_high), .LOAD_LOW_IN(load_low),
      .SENSE_OPEN_IN(s_open), .FB_OPEN_IN(2'h0), .COMP_LOW_IN(comp_low), .RAMP_BUSY_IN(ramp),
      .TIMING_OPEN_IN(t_open), .HEAT_WARN_IN(1'b0), .HEAT_SHUT_IN(heat_shut),
      .CH_RUN(ch_run), .COMP_PULL(pull), .ON_TIME_END(ot_end), .CAP_SEL0(), .CAP_SEL1(),
      .REF_CV(), .FAULT_N(fault_n));
   power_stage_model stage (.clk(clk), .pull(pull), .sw_clk(sw_clk), .comp_low(comp_low));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 chk("rdata", e, rdata);
   endtask : rd
   task automatic run_is(input logic [1:0] e, input int n);
      repeat (n) @(posedge clk);
      #1 chk("ch_run", {6'h0, e}, {6'h0, ch_run});
   endtask : run_is
   task automatic wait_run(input logic [1:0] e, input int n);
      @(posedge clk);
      #1;
      for (int i = 0; i < n && ch_run !== e; i++) begin
         @(posedge clk);
         #1;
      end
      chk("ch_run", {6'h0, e}, {6'h0, ch_run});
   endtask : wait_run
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      wrap_up();
   end
   initial begin
      // row: write flag, address, write data, expected read
      rows = '{{1'b0, fault_pkg::A_EN_A, 8'h00, fault_pkg::RST_EN_A},
         {1'b0, fault_pkg::A_EN_B, 8'h00, 8'h00}, {1'b0, fault_pkg::A_LATCH, 8'h00, 8'h00},
         {1'b0, fault_pkg::A_FLAGS_B, 8'h00, fault_pkg::RST_FLAGS_B},
         {1'b0, fault_pkg::A_FLAGS_B, 8'h00, 8'h00}, {1'b0, fault_pkg::A_STATUS, 8'h00, 8'h00},
         {1'b1, 4'hf, 8'h5a, 8'h00}, {1'b1, fault_pkg::A_LATCH, 8'h0f, 8'h0f},
         {1'b1, fault_pkg::A_STATUS, 8'h33, 8'h00}};
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         if (rows[i][20])
            wr(rows[i][19:16], rows[i][15:8]);
         rd(rows[i][19:16], rows[i][7:0]);
      end
      wr(fault_pkg::A_LATCH, 8'h00);
      $display("register table done");
      wr(fault_pkg::A_CTRL, 8'h01);
      wait_run(2'h1, 60);
      @(posedge clk) fb_high <= 2'h1;
      run_is(2'h0, 8);
      chk("fault_n", 8'h02, {6'h0, fault_n});
      rd(fault_pkg::A_FLAGS_A, 8'h01);
      @(posedge clk) fb_high <= 2'h0;
      wait_run(2'h1, 60);
      rd(fault_pkg::A_FLAGS_A, 8'h01);
      rd(fault_pkg::A_FLAGS_A, 8'h00);
      wr(fault_pkg::A_CTRL, 8'h11);
      repeat (4) @(posedge clk);
      #1 chk("fault_n", 8'h03, {6'h0, fault_n});
      $display("over-voltage test done");
      wr(fault_pkg::A_EN_A, 8'h73);
      @(posedge clk) ramp <= 2'h1;
      fb_low <= 2'h1;
      run_is(2'h1, 10);
      @(posedge clk) ramp <= 2'h0;
      run_is(2'h0, 8);
      @(posedge clk) fb_low <= 2'h0;
      run_is(2'h0, 3000);
      wait_run(2'h1, 2500);
      $display("timed under-voltage test done");
      wr(fault_pkg::A_LATCH, 8'h02);
      @(posedge clk) fb_low <= 2'h1;
      run_is(2'h0, 8);
      @(posedge clk) fb_low <= 2'h0;
      run_is(2'h0, 200);
      wr(fault_pkg::A_CTRL, 8'h01);
      wait_run(2'h1, 60);
      $display("latched under-voltage test done");
      wr(fault_pkg::A_LATCH, 8'h00);
      wr(fault_pkg::A_EN_B, 8'h01);
      @(posedge clk) sw_cap <= 2'h1;
      repeat (4) @(posedge clk);
      #1 chk("ot_end", 8'h01, {6'h0, ot_end});
      @(posedge clk) sw_cap <= 2'h0;
      run_is(2'h0, 4);
      wait_run(2'h1, 600);
      $display("limit test done");
      wr(fault_pkg::A_CTRL, 8'h03);
      wait_run(2'h3, 60);
      @(posedge clk) t_open <= 1'b1;
      repeat (6) @(posedge clk);
      t_open <= 1'b0;
      run_is(2'h0, 50);
      wr(fault_pkg::A_CTRL, 8'h03);
      wait_run(2'h3, 60);
      @(posedge clk) load_low <= 2'h1;
      run_is(2'h3, 8);
      rd(fault_pkg::A_FLAGS_B, 8'h11);
      @(posedge clk) heat_shut <= 1'b1;
      repeat (6) @(posedge clk);
      heat_shut <= 1'b0;
      wait_run(2'h3, 60);
      $display("pin and heat test done");
      wr(fault_pkg::A_LATCH, 8'h09);
      wr(fault_pkg::A_EN_B, 8'h06);
      @(posedge clk) load_high <= 2'h1;
      run_is(2'h2, 8);
      @(posedge clk) load_high <= 2'h0;
      run_is(2'h2, 50);
      wr(fault_pkg::A_CTRL, 8'h03);
      wait_run(2'h3, 60);
      @(posedge clk) fb_high <= 2'h1;
      run_is(2'h2, 8);
      @(posedge clk) fb_high <= 2'h0;
      run_is(2'h2, 50);
      wr(fault_pkg::A_CTRL, 8'h03);
      wait_run(2'h3, 60);
      @(posedge clk) s_open <= 2'h1;
      run_is(2'h2, 8);
      wr(fault_pkg::A_CTRL, 8'h03);
      run_is(2'h2, 20);
      @(posedge clk) s_open <= 2'h0;
      wr(fault_pkg::A_CTRL, 8'h03);
      wait_run(2'h3, 60);
      rd(fault_pkg::A_FLAGS_A, 8'h0f);
      rd(fault_pkg::A_FLAGS_B, 8'h03);
      $display("latch and open pin test done");
      wrap_up();
   end
endmodule : fault_protect_tb
